// ==== include/dbc_map.svh ====
// Constants of the DAC bank command block: frame layout, codes, timing.
// Assumes nothing; included by the package and the design.
`ifndef DBC_MAP_SVH
`define DBC_MAP_SVH

`define DBC_FRAME_BITS   6'd32
`define DBC_LAST_BIT     6'd31
`define DBC_CMD_HI       27
`define DBC_CMD_LO       24
`define DBC_PD_HI        9
`define DBC_PD_LO        8
`define DBC_REF_BIT      0

`define DBC_CMD_PWRDN    4'h4
`define DBC_CMD_CLRCODE  4'h5
`define DBC_CMD_RESET    4'h7
`define DBC_CMD_REF      4'h8

`define DBC_CODE_ZERO    12'h000
`define DBC_CODE_MID     12'h800
`define DBC_CODE_FULL    12'hFFF
`define DBC_CLR_NOP      2'h3
`define DBC_CLR_RESET    2'h0
`define DBC_PD_RESET     2'h0

`define DBC_CLK_NS       10
`define DBC_POR_NS       1000
`define DBC_POR_CYCLES   ((`DBC_POR_NS + `DBC_CLK_NS - 1) / `DBC_CLK_NS)

`endif

// ==== include/dbc_pkg.sv ====
// Types and the clear-code lookup for the DAC bank command block.
// Assumes dbc_map.svh is on the include path.
package dbc_pkg;
  `include "dbc_map.svh"

  typedef logic [3:0]  dbc_cmd_t;
  typedef logic [11:0] dbc_code_t;

  typedef enum logic [1:0] {
    DBC_PD_NORMAL = 2'h0,
    DBC_PD_1K     = 2'h1,
    DBC_PD_100K   = 2'h2,
    DBC_PD_TRI    = 2'h3
  } dbc_pd_mode_t;

  function automatic dbc_code_t dbc_clear_value(input logic [1:0] sel);
    dbc_code_t v;
    v = `DBC_CODE_ZERO;
    if (sel == 2'h1) begin
      v = `DBC_CODE_MID;
    end else if (sel == 2'h2) begin
      v = `DBC_CODE_FULL;
    end
    return v;
  endfunction : dbc_clear_value
endpackage : dbc_pkg

// ==== rtl/dbc_top.sv ====
// Command interpreter for one bank of eight DAC channels.
// Assumes the serial link pins are asynchronous to clk and that a
// second instance, on the other frame select, serves the other bank.
//
// Notes on behaviour
// - Frame valid after 32 serial clock falls with select low; acts on 32nd.
// - Select rising before the 32nd fall aborts and clears the shifter.
// - An aborted frame changes no register and no mode.
// - Reference enable is off after power-up.
// - Command 1000 loads reference enable from bit 0.
// - Power-on reset brings all outputs to zero code.
// - Command 0111 repeats the power-on reset.
// - Strobe and clear input are ignored while power-on reset runs.
// - Command 0100 applies the mode in bits 9:8 to selected channels.
// - Bits 7 to 0 select channels; unselected channels keep their mode.
// - Reference is powered while enabled, unless every channel is powered down.
// - Power-down leaves the stored DAC codes untouched.
// - On power-up, strobe low loads input code, strobe high keeps DAC code.
// - Clear input falling loads input and DAC codes with the clear code.
// - Clear select 0,1,2 give codes 0x000, 0x800, 0xFFF; 3 does nothing.
// - Clear select resets to the zero-code setting.
// - Command 0101 loads clear select from bits 1:0.
// - Clear mode lasts until the 32nd fall of the next frame.
// - Clear falling during a frame aborts that frame.
// - Data shifts in MSB first on serial clock falls while select is low.
// - Command sits in bits 27:24, address in 23:20, data below.
// - Each bank has its own select; both low write both banks.
`timescale 1ns/100ps
`include "dbc_map.svh"

module dbc_top
  import dbc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              dac_serial_clock,
  input  wire logic              dac_serial_data_in,
  input  wire logic              bank_frame_select_n,
  input  wire logic              load_update_strobe_n,
  input  wire logic              async_clear_n,
  output logic [7:0][11:0]       dac_code_q,
  output logic [7:0][1:0]        pd_mode_q,
  output logic                   ref_enable_q,
  output logic                   ref_powered_q,
  output logic                   clear_mode_q,
  output logic                   por_busy_q,
  output logic                   frame_done_q,
  output logic                   frame_abort_q
);

  ////////////////////////////////////////////////////////////////////
  // Synchronisers. The first stage is read only by the second.

  logic [2:0] sclk_s_q;
  logic [1:0] din_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] load_update_strobe_n_s_q;
  logic [2:0] clr_s_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_s_q <= 3'h0;
      din_s_q  <= 2'h0;
      cs_s_q   <= 2'h3;
      load_update_strobe_n_s_q <= 2'h3;
      clr_s_q  <= 3'h7;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], dac_serial_clock};
      din_s_q  <= {din_s_q[0], dac_serial_data_in};
      cs_s_q   <= {cs_s_q[0], bank_frame_select_n};
      load_update_strobe_n_s_q <= {load_update_strobe_n_s_q[0], load_update_strobe_n};
      clr_s_q  <= {clr_s_q[1:0], async_clear_n};
    end
  end

  logic sclk_fall;
  logic clr_fall;
  logic cs_high;
  logic din_s;
  logic load_update_strobe_n_low;

  assign sclk_fall = sclk_s_q[2] & ~sclk_s_q[1];
  assign clr_fall  = clr_s_q[2] & ~clr_s_q[1];
  assign cs_high   = cs_s_q[1];
  assign din_s     = din_s_q[1];
  assign load_update_strobe_n_low  = ~load_update_strobe_n_s_q[1];

  ////////////////////////////////////////////////////////////////////
  // Frame shifter.

  logic [31:0] shift_q;
  logic [5:0]  bit_cnt_q;
  logic        dead_q;
  logic [31:0] word;
  logic        in_frame;
  logic        clr_event;
  logic        clr_abort;
  logic        exec;
  logic        soft_rst;
  dbc_cmd_t    cmd;

  assign word     = {shift_q[30:0], din_s};
  assign cmd      = word[`DBC_CMD_HI:`DBC_CMD_LO];
  assign in_frame = (bit_cnt_q != 6'h00) && (bit_cnt_q != `DBC_FRAME_BITS);
  // A clear once select is low kills the frame, even before its first bit.
  assign clr_abort = clr_event && !cs_high &&
                     (bit_cnt_q != `DBC_FRAME_BITS);
  // The select belongs to this bank alone.
  assign exec = !cs_high && sclk_fall && !dead_q && !clr_abort &&
                (bit_cnt_q == `DBC_LAST_BIT);
  assign soft_rst = exec && (cmd == `DBC_CMD_RESET);

  always_ff @(posedge clk) begin
    if (reset) begin
      shift_q   <= 32'h0000_0000;
      bit_cnt_q <= 6'h00;
      dead_q    <= 1'b0;
    end else if (cs_high) begin
      // An early rise leaves nothing behind to execute later.
      shift_q   <= 32'h0000_0000;
      bit_cnt_q <= 6'h00;
      dead_q    <= 1'b0;
    end else if (clr_abort) begin
      shift_q   <= 32'h0000_0000;
      bit_cnt_q <= 6'h00;
      dead_q    <= 1'b1;
    end else if (sclk_fall && !dead_q &&
                 (bit_cnt_q != `DBC_FRAME_BITS)) begin
      shift_q   <= word;
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_done_q  <= 1'b0;
      frame_abort_q <= 1'b0;
    end else begin
      frame_done_q  <= exec;
      frame_abort_q <= clr_abort || (cs_high && in_frame);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power-on reset timer, restarted by the reset command.

  logic [7:0] por_cnt_q;

  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      por_cnt_q  <= 8'(`DBC_POR_CYCLES);
      por_busy_q <= 1'b1;
    end else if (por_cnt_q != 8'h00) begin
      por_cnt_q  <= por_cnt_q - 8'h01;
      por_busy_q <= (por_cnt_q != 8'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode registers.

  logic [1:0] clear_sel_q;

  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      ref_enable_q <= 1'b0;
      clear_sel_q  <= `DBC_CLR_RESET;
    end else if (exec) begin
      // Reserved codes fall through and touch nothing.
      if (cmd == `DBC_CMD_REF) begin
        ref_enable_q <= word[`DBC_REF_BIT];
      end
      if (cmd == `DBC_CMD_CLRCODE) begin
        clear_sel_q <= word[1:0];
      end
    end
  end

  // The clear-select value 3 never fires a clear.
  assign clr_event = clr_fall && !por_busy_q &&
                     (clear_sel_q != `DBC_CLR_NOP);

  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      clear_mode_q <= 1'b0;
    end else if (clr_event) begin
      clear_mode_q <= 1'b1;
    end else if (exec) begin
      clear_mode_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-channel state. Data write commands live elsewhere, so the
  // input code changes only by reset and clear here.

  logic [7:0][11:0] input_code_q;
  logic             pd_cmd;
  logic [1:0]       pd_new;

  assign pd_cmd = exec && (cmd == `DBC_CMD_PWRDN);
  assign pd_new = word[`DBC_PD_HI:`DBC_PD_LO];

  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      for (int i = 0; i < 8; i++) begin
        input_code_q[i] <= `DBC_CODE_ZERO;
        dac_code_q[i]   <= `DBC_CODE_ZERO;
        pd_mode_q[i]    <= `DBC_PD_RESET;
      end
    end else if (clr_event) begin
      for (int i = 0; i < 8; i++) begin
        input_code_q[i] <= dbc_clear_value(clear_sel_q);
        dac_code_q[i]   <= dbc_clear_value(clear_sel_q);
      end
    end else if (pd_cmd) begin
      for (int i = 0; i < 8; i++) begin
        if (word[i]) begin
          pd_mode_q[i] <= pd_new;
          // Wake-up follows the strobe level; codes stay in sleep.
          if (pd_mode_q[i] != DBC_PD_NORMAL &&
              pd_new == DBC_PD_NORMAL && load_update_strobe_n_low && !por_busy_q) begin
            dac_code_q[i] <= input_code_q[i];
          end
        end
      end
    end
  end

  // Shared reference circuitry sleeps with the whole bank or while reference enable is off.
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_powered_q <= 1'b0;
    end else begin
      ref_powered_q <= ref_enable_q &&
                       !(&{pd_mode_q[7] != 2'h0, pd_mode_q[6] != 2'h0,
                           pd_mode_q[5] != 2'h0, pd_mode_q[4] != 2'h0,
                           pd_mode_q[3] != 2'h0, pd_mode_q[2] != 2'h0,
                           pd_mode_q[1] != 2'h0,
                           pd_mode_q[0] != 2'h0});
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_exec_on_last: assert property (
    frame_done_q |-> $past(bit_cnt_q) == `DBC_LAST_BIT &&
                     bit_cnt_q == `DBC_FRAME_BITS)
    else $error("frame executed before its 32nd bit");

  a_early_rise_clears: assert property (
    cs_high && in_frame |=> shift_q == 32'h0000_0000 &&
                            bit_cnt_q == 6'h00 && !frame_done_q)
    else $error("early select rise did not clear the shifter");

  a_abort_no_change: assert property (
    cs_high && in_frame && !clr_event |=>
      $stable(ref_enable_q) && $stable(pd_mode_q) &&
      $stable(clear_sel_q) && $stable(dac_code_q))
    else $error("aborted frame changed state");

  a_ref_load: assert property (
    exec && cmd == `DBC_CMD_REF && !soft_rst |=>
      ref_enable_q == $past(word[0]))
    else $error("reference enable not loaded from bit 0");

  a_soft_reset: assert property (
    soft_rst |=> !ref_enable_q && por_busy_q &&
                 dac_code_q == '0 && pd_mode_q == '0 ##1 por_busy_q)
    else $error("reset command did not restore reset state");

  a_por_ignores_clear: assert property (
    por_busy_q && clr_fall |=> $stable(clear_mode_q) ||
                               !clear_mode_q)
    else $error("clear acted during power-on reset");

  a_pd_select: assert property (
    pd_cmd && !word[0] |=> $stable(pd_mode_q[0]))
    else $error("unselected channel changed mode");

  a_pd_keeps_code: assert property (
    pd_cmd && pd_new != 2'h0 |=> $stable(dac_code_q))
    else $error("power-down altered stored codes");

  a_clear_code: assert property (
    clr_event && clear_sel_q == 2'h2 |=>
      dac_code_q[7] == 12'hFFF && input_code_q[0] == 12'hFFF &&
      clear_mode_q)
    else $error("clear did not load full-scale code");

  a_clear_nop: assert property (
    clr_fall && clear_sel_q == `DBC_CLR_NOP && !pd_cmd && !soft_rst
      |=> $stable(dac_code_q))
    else $error("no-operation clear changed codes");

  a_clear_mode_exit: assert property (
    clear_mode_q && exec && !clr_event |=> !clear_mode_q)
    else $error("clear mode did not end on the next frame");

  a_clear_aborts: assert property (
    clr_abort |=> !frame_done_q && bit_cnt_q == 6'h00 && dead_q)
    else $error("clear did not abort the running frame");

  a_ref_power: assert property (
    ref_enable_q && pd_mode_q[3] == 2'h0 |=> ref_powered_q ||
                                            !ref_enable_q)
    else $error("reference powered off with a channel active");

  a_reserved_idle: assert property (
    exec && cmd[3] && cmd != `DBC_CMD_REF && !clr_event |=>
      $stable(ref_enable_q) && $stable(clear_sel_q) &&
      $stable(pd_mode_q) && $stable(dac_code_q))
    else $error("reserved command changed state");

  a_shift_msb_first: assert property (
    !cs_high && !clr_abort && sclk_fall && !dead_q &&
    bit_cnt_q != `DBC_FRAME_BITS |=>
      shift_q == {$past(shift_q[30:0]), $past(din_s)})
    else $error("serial bit not shifted in behind the others");

  a_pd_apply: assert property (
    pd_cmd && word[7] |=> pd_mode_q[7] == $past(pd_new))
    else $error("selected channel did not take the new mode");

  a_clear_sel_load: assert property (
    exec && cmd == `DBC_CMD_CLRCODE |=> clear_sel_q == $past(word[1:0]))
    else $error("clear select not loaded from bits 1:0");

  a_clear_mid_code: assert property (
    clr_event && clear_sel_q == 2'h1 |=>
      dac_code_q[0] == 12'h800 && input_code_q[7] == 12'h800 &&
      clear_mode_q)
    else $error("clear did not load the midscale code");

  a_reset_clear_sel: assert property (
    soft_rst |=> clear_sel_q == `DBC_CLR_RESET && !clear_mode_q)
    else $error("reset command did not restore clear select");

  a_wake_keeps_code: assert property (
    pd_cmd && !load_update_strobe_n_low |=> $stable(dac_code_q))
    else $error("wake with strobe high changed stored codes");

  a_wake_loads_input: assert property (
    pd_cmd && word[0] && pd_new == 2'h0 && pd_mode_q[0] != 2'h0 &&
    load_update_strobe_n_low && !por_busy_q |=> dac_code_q[0] == $past(input_code_q[0]))
    else $error("wake with strobe low did not load the input code");

endmodule : dbc_top

// ==== dv/dbc_host_model.sv ====
// Host serial port model that frames commands onto one bank's link pins.
// Assumes clk is the bench clock; frames start just after its rising edge.
`timescale 1ns/100ps

module dbc_host_model (
  input  wire logic clk,
  output logic      dac_serial_clock,
  output logic      dac_serial_data_in,
  output logic      bank_frame_select_n
);
  initial begin
    dac_serial_clock    = 1'b1;
    dac_serial_data_in  = 1'b0;
    bank_frame_select_n = 1'b1;
  end

  // Sends the first nbits of frame; fewer than 32 cuts the frame short.
  task automatic send(input logic [31:0] frame, input int nbits);
    @(posedge clk);
    #1 bank_frame_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      dac_serial_data_in = frame[31-i];
      #40 dac_serial_clock = 1'b0;
      #40 dac_serial_clock = 1'b1;
    end
    #40 bank_frame_select_n = 1'b1;
    // A released data line must not keep showing the last bit.
    dac_serial_data_in = ~dac_serial_data_in;
    #80;
  endtask : send
endmodule : dbc_host_model

// ==== dv/testbench.sv ====
// Self-checking bench for the DAC bank command block.
// Assumes the host model drives the link and the bench drives the rest.
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  bad_count++; $display("Error t=%0t got %h exp %h", $time, got, exp); \
  end end

module testbench;
  import dbc_pkg::*;

  logic             clk;
  logic             reset;
  logic             dac_serial_clock;
  logic             dac_serial_data_in;
  logic             bank_frame_select_n;
  logic             load_update_strobe_n;
  logic             async_clear_n;
  logic [7:0][11:0] dac_code_q;
  logic [7:0][1:0]  pd_mode_q;
  logic             ref_enable_q;
  logic             ref_powered_q;
  logic             clear_mode_q;
  logic             por_busy_q;
  logic             frame_done_q;
  logic             frame_abort_q;
  int               bad_count;
  int               total_checks;
  int               done_count;
  int               abort_count;
  int               cycles;
  logic [1:0]       sels [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  logic [11:0]      codes [4] = '{12'h800, 12'h000, 12'hFFF, 12'hFFF};

  dbc_host_model host (.clk(clk), .dac_serial_clock(dac_serial_clock),
    .dac_serial_data_in(dac_serial_data_in),
    .bank_frame_select_n(bank_frame_select_n));

  dbc_top dut (.clk(clk), .reset(reset),
    .dac_serial_clock(dac_serial_clock),
    .dac_serial_data_in(dac_serial_data_in),
    .bank_frame_select_n(bank_frame_select_n),
    .load_update_strobe_n(load_update_strobe_n),
    .async_clear_n(async_clear_n), .dac_code_q(dac_code_q),
    .pd_mode_q(pd_mode_q), .ref_enable_q(ref_enable_q),
    .ref_powered_q(ref_powered_q), .clear_mode_q(clear_mode_q),
    .por_busy_q(por_busy_q), .frame_done_q(frame_done_q),
    .frame_abort_q(frame_abort_q));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cycles++;
    if (frame_done_q === 1'b1) done_count++;
    if (frame_abort_q === 1'b1) abort_count++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] frm(input logic [3:0] cmd,
                                      input logic [15:0] low);
    return {4'hF, cmd, 4'h5, 4'h0, low};
  endfunction : frm

  task automatic pulse_clear();
    @(posedge clk);
    #1 async_clear_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 async_clear_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask : pulse_clear

  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    async_clear_n = 1'b1;
    load_update_strobe_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    @(posedge clk);
    #1;
    `CHK(por_busy_q, 1'b1)
    `CHK(ref_enable_q, 1'b0)
    `CHK(dac_code_q, {8{12'h000}})
    pulse_clear();
    `CHK(clear_mode_q, 1'b0)
    repeat (100) @(posedge clk);
    #1;
    `CHK(por_busy_q, 1'b0)
    host.send(frm(4'h8, 16'h0001), 32);
    `CHK(ref_enable_q, 1'b1)
    `CHK(ref_powered_q, 1'b1)
    host.send(frm(4'h8, 16'h0000), 31);
    `CHK(ref_enable_q, 1'b1)
    `CHK(abort_count, 1)
    fork
      host.send(frm(4'h8, 16'h0000), 32);
      pulse_clear();
    join
    `CHK(ref_enable_q, 1'b1)
    `CHK(abort_count, 2)
    `CHK(clear_mode_q, 1'b1)
    for (int i = 0; i < 4; i++) begin
      host.send(frm(4'h5, 16'hFFFC | 16'(sels[i])), 32);
      `CHK(clear_mode_q, 1'b0)
      pulse_clear();
      `CHK(dac_code_q, {8{codes[i]}})
      `CHK(clear_mode_q, 1'(i < 3))
    end
    for (int c = 9; c < 16; c++) host.send(frm(4'(c), 16'hFFFF), 32);
    `CHK(ref_enable_q, 1'b1)
    `CHK(pd_mode_q, 16'h0000)
    `CHK(done_count, 12)
    for (int m = 1; m < 4; m++) begin
      host.send(frm(4'h4, {6'h00, 2'(m), 8'hFF}), 32);
      `CHK(pd_mode_q, {8{2'(m)}})
      `CHK(ref_powered_q, 1'b0)
      `CHK(dac_code_q, {8{12'hFFF}})
    end
    host.send(frm(4'h4, 16'h00F0), 32);
    `CHK(pd_mode_q, {{4{2'h0}}, {4{2'h3}}})
    `CHK(ref_powered_q, 1'b1)
    `CHK(dac_code_q, {8{12'hFFF}})
    load_update_strobe_n = 1'b0;
    host.send(frm(4'h4, 16'h000F), 32);
    `CHK(pd_mode_q, 16'h0000)
    `CHK(dac_code_q, {8{12'hFFF}})
    host.send(frm(4'h7, 16'h0000), 32);
    `CHK(ref_enable_q, 1'b0)
    `CHK(pd_mode_q, 16'h0000)
    `CHK(dac_code_q, {8{12'h000}})
    `CHK(por_busy_q, 1'b1)
    summarize();
  end
endmodule : testbench
